// file: rtl/pmo_pkg.sv
// Purpose: shared constants of the power monitor output port
// Assumes: 16-bit configuration and result words, byte-wide bus packets
// Notes:   counts are signed, full scale at +/-256
package pmo_pkg;

   // -------------------------------------------------------------------
   // command codes
   // -------------------------------------------------------------------
   localparam logic [7:0] CMD_CONFIG   = 8'hd0;
   localparam logic [7:0] CMD_RD_VOLT  = 8'h8b;
   localparam logic [7:0] CMD_RD_CURR  = 8'h8c;
   localparam logic [7:0] CMD_RD_POWER = 8'h96;

   // -------------------------------------------------------------------
   // configuration word
   // -------------------------------------------------------------------
   localparam logic [15:0] CFG_RESET   = 16'h0000;
   localparam int          SEL_LSB     = 6;
   localparam int          SEL_MSB     = 7;
   localparam logic [1:0]  SEL_POWER   = 2'h0;
   localparam logic [1:0]  SEL_VOLT    = 2'h1;
   localparam logic [1:0]  SEL_CURR    = 2'h2;
   localparam logic [1:0]  SEL_UNDEF   = 2'h3;

   // -------------------------------------------------------------------
   // result word
   // -------------------------------------------------------------------
   localparam int                 FRAC_BITS    = 6;
   localparam logic signed [15:0] FS_POS       = 16'sh0100;
   localparam logic signed [15:0] FS_NEG       = -16'sh0100;
   localparam logic [15:0]        RESULT_RESET = 16'h0000;
   localparam logic               BUS_ACK      = 1'b0;
   localparam logic               BUS_IDLE     = 1'b1;

   // clamp a signed count to full scale and pack it with six pad zeros
   function automatic logic [15:0] pack_count(logic signed [15:0] cnt);
      logic signed [15:0] c;
      c = cnt;
      if (c > FS_POS) c = FS_POS;
      if (c < FS_NEG) c = FS_NEG;
      return {c[15-FRAC_BITS:0], {FRAC_BITS{1'b0}}};
   endfunction

   function automatic logic is_read_cmd(logic [7:0] cmd);
      return (cmd == CMD_RD_VOLT) || (cmd == CMD_RD_CURR) ||
             (cmd == CMD_RD_POWER);
   endfunction

endpackage

// file: rtl/pmo_bus_evt_if.sv
// Purpose: bus line events from the line sampler to the packet engine
// Assumes: all signals on ref_clk
// Notes:   events are one-cycle pulses, sda is a level
interface pmo_bus_evt_if;
   logic scl_rise;
   logic scl_fall;
   logic start;
   logic stop;
   logic sda;

   modport src (output scl_rise, output scl_fall, output start,
                output stop, output sda);
   modport dst (input scl_rise, input scl_fall, input start,
                input stop, input sda);
endinterface

// file: rtl/pmo_line_sync.sv
// Purpose: synchronise bus clock and data lines and find their events
// Assumes: bus clock far slower than ref_clk
// Notes:   first sync stage feeds only the second
module pmo_line_sync
   import pmo_pkg::*;
(
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic rst_b,
   // bus lines
   input  wire logic scl_i,
   input  wire logic sda_i,
   // events
   pmo_bus_evt_if.src evt
);

   logic scl_m_q, scl_s_q, scl_d_q;
   logic sda_m_q, sda_s_q, sda_d_q;

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         scl_m_q <= BUS_IDLE;
         scl_s_q <= BUS_IDLE;
         scl_d_q <= BUS_IDLE;
         sda_m_q <= BUS_IDLE;
         sda_s_q <= BUS_IDLE;
         sda_d_q <= BUS_IDLE;
      end else begin
         scl_m_q <= scl_i;
         scl_s_q <= scl_m_q;
         scl_d_q <= scl_s_q;
         sda_m_q <= sda_i;
         sda_s_q <= sda_m_q;
         sda_d_q <= sda_s_q;
      end
   end

   assign evt.scl_rise = scl_s_q & ~scl_d_q;
   assign evt.scl_fall = ~scl_s_q & scl_d_q;
   assign evt.start    = scl_s_q & scl_d_q & sda_d_q & ~sda_s_q;
   assign evt.stop     = scl_s_q & scl_d_q & ~sda_d_q & sda_s_q;
   assign evt.sda      = sda_s_q;

endmodule // pmo_line_sync

// file: rtl/pmo_output_port.sv
// Purpose: host register access of a power monitor over a two-wire bus
// Assumes: sample_valid and counts come from logic on ref_clk
// Notes:   open-drain data line, oe high while pulling low
//
// What this block does
// - result register loads signed count of the type the config selects
// - full scale reads 0x4000, negative full scale 0xc000, zero as zero
// - binary point sits above the six lowest bits of the word
// - top bit of the result word is the two's complement sign
// - six lowest result bits always read as zero
// - select 01 voltage, 10 current, 00 power
// - one result register only, holding the latest selected type
// - codes 8b, 8c and 96 all read the same result register
// - read: start, address+w, command, restart, address+r, low, high
// - ack is 0, nack is 1; master nacks the high byte then stops
// - configuration register is a 16-bit word at command d0
// - select field resets to 00; value 11 is not accepted
// - new select reaches the result only at the next sample load
module pmo_output_port
   import pmo_pkg::*;
#(
   parameter logic [6:0] SLAVE_ADDR = 7'h10
)
(
   // clock and reset
   input  wire logic               ref_clk,
   input  wire logic               rst_b,
   // bus pins
   input  wire logic               scl_i,
   input  wire logic               sda_i,
   output logic                    sda_o,
   output logic                    sda_oe,
   // measurement path
   input  wire logic               sample_valid,
   input  wire logic signed [15:0] volt_count,
   input  wire logic signed [15:0] curr_count,
   input  wire logic signed [15:0] power_count,
   // register contents
   output logic             [15:0] config_word,
   output logic             [15:0] measurement_result
);

   typedef enum logic [3:0] {
      ST_IDLE, ST_ADDR, ST_CMD, ST_WLO, ST_WHI, ST_ACK, ST_RD, ST_RACK
   } pmo_state_e;

   pmo_bus_evt_if evt ();

   pmo_line_sync u_sync (
      .ref_clk (ref_clk),
      .rst_b   (rst_b),
      .scl_i   (scl_i),
      .sda_i   (sda_i),
      .evt     (evt)
   );

   pmo_state_e  state_q, after_q;
   logic [7:0]  rx_q;
   logic [3:0]  cnt_q;
   logic [7:0]  cmd_q;
   logic        cmd_ok_q;
   logic [7:0]  wlo_q;
   logic [7:0]  tx_q;
   logic [7:0]  tx_hi_q;
   logic        hi_sent_q;
   logic        cfg_we;
   logic [15:0] cfg_new;

   // -------------------------------------------------------------------
   // result register
   // -------------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         measurement_result <= RESULT_RESET;
      end else if (sample_valid) begin
         unique case (config_word[SEL_MSB:SEL_LSB])
            SEL_VOLT: measurement_result <= pack_count(volt_count);
            SEL_CURR: measurement_result <= pack_count(curr_count);
            SEL_POWER: measurement_result <= pack_count(power_count);
            default: measurement_result <= measurement_result;
         endcase
      end
   end

   // -------------------------------------------------------------------
   // configuration register
   // -------------------------------------------------------------------
   always_comb begin
      cfg_new = {rx_q, wlo_q};
      if (wlo_q[SEL_MSB:SEL_LSB] == SEL_UNDEF) begin
         cfg_new[SEL_MSB:SEL_LSB] = config_word[SEL_MSB:SEL_LSB];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         config_word <= CFG_RESET;
      end else if (cfg_we) begin
         config_word <= cfg_new;
      end
   end

   assign cfg_we = (state_q == ST_WHI) && evt.scl_fall && (cnt_q == 4'h8)
                   && (cmd_q == CMD_CONFIG);

   // -------------------------------------------------------------------
   // packet engine
   // -------------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         state_q   <= ST_IDLE;
         after_q   <= ST_IDLE;
         rx_q      <= 8'h00;
         cnt_q     <= 4'h0;
         cmd_q     <= 8'h00;
         cmd_ok_q  <= 1'b0;
         wlo_q     <= 8'h00;
         tx_q      <= 8'h00;
         tx_hi_q   <= 8'h00;
         hi_sent_q <= 1'b0;
         sda_o     <= BUS_IDLE;
         sda_oe    <= 1'b0;
      end else if (evt.start) begin
         state_q <= ST_ADDR;
         cnt_q   <= 4'h0;
         sda_o   <= BUS_IDLE;
         sda_oe  <= 1'b0;
      end else if (evt.stop) begin
         state_q  <= ST_IDLE;
         cmd_ok_q <= 1'b0;
         sda_o    <= BUS_IDLE;
         sda_oe   <= 1'b0;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               sda_oe <= 1'b0;
            end
            ST_ADDR, ST_CMD, ST_WLO, ST_WHI: begin
               if (evt.scl_rise && cnt_q != 4'h8) begin
                  rx_q  <= {rx_q[6:0], evt.sda};
                  cnt_q <= cnt_q + 4'h1;
               end else if (evt.scl_fall && cnt_q == 4'h8) begin
                  cnt_q   <= 4'h0;
                  state_q <= ST_ACK;
                  after_q <= ST_IDLE;
                  sda_o   <= BUS_ACK;
                  sda_oe  <= 1'b1;
                  unique case (state_q)
                     ST_ADDR: begin
                        if (rx_q[7:1] != SLAVE_ADDR) begin
                           sda_oe <= 1'b0;
                        end else if (!rx_q[0]) begin
                           after_q <= ST_CMD;
                        end else if (cmd_ok_q) begin
                           after_q   <= ST_RD;
                           hi_sent_q <= 1'b0;
                           if (cmd_q == CMD_CONFIG) begin
                              tx_q    <= config_word[7:0];
                              tx_hi_q <= config_word[15:8];
                           end else begin
                              tx_q    <= measurement_result[7:0];
                              tx_hi_q <= measurement_result[15:8];
                           end
                        end else begin
                           sda_oe <= 1'b0;
                        end
                     end
                     ST_CMD: begin
                        cmd_q <= rx_q;
                        if (rx_q == CMD_CONFIG || is_read_cmd(rx_q)) begin
                           cmd_ok_q <= 1'b1;
                           after_q  <= ST_WLO;
                        end else begin // unknown codes nacked
                           cmd_ok_q <= 1'b0;
                           sda_oe   <= 1'b0;
                        end
                     end
                     ST_WLO: begin
                        wlo_q <= rx_q;
                        if (cmd_q == CMD_CONFIG) begin
                           after_q <= ST_WHI;
                        end else begin
                           sda_oe <= 1'b0;
                        end
                     end
                     default: begin // high byte acked, no more
                        cmd_ok_q <= 1'b0;
                        if (cmd_q != CMD_CONFIG) begin
                           sda_oe <= 1'b0;
                        end
                     end
                  endcase
               end
            end
            ST_ACK: begin
               if (evt.scl_fall) begin
                  state_q <= after_q;
                  cnt_q   <= 4'h0;
                  sda_oe  <= 1'b0;
                  sda_o   <= BUS_IDLE;
                  if (after_q == ST_RD) begin
                     sda_o  <= tx_q[7];
                     sda_oe <= ~tx_q[7];
                     tx_q   <= {tx_q[6:0], 1'b0};
                     cnt_q  <= 4'h1;
                  end
               end
            end
            ST_RD: begin
               if (evt.scl_fall) begin
                  if (cnt_q == 4'h8) begin
                     state_q <= ST_RACK;
                     sda_o   <= BUS_IDLE;
                     sda_oe  <= 1'b0;
                  end else begin
                     sda_o  <= tx_q[7];
                     sda_oe <= ~tx_q[7];
                     tx_q   <= {tx_q[6:0], 1'b0};
                     cnt_q  <= cnt_q + 4'h1;
                  end
               end
            end
            ST_RACK: begin
               if (evt.scl_rise) begin
                  if (evt.sda == BUS_ACK && !hi_sent_q) begin
                     state_q   <= ST_ACK;
                     after_q   <= ST_RD;
                     tx_q      <= tx_hi_q;
                     hi_sent_q <= 1'b1;
                  end else begin // nack ends the read
                     state_q  <= ST_IDLE;
                     cmd_ok_q <= 1'b0;
                  end
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

endmodule // pmo_output_port

// file: sim/pmo_output_port_monitor.sv
// Purpose: checker on the output port's top-level ports
// Assumes: single ref_clk domain
// Notes:   bound into every pmo_output_port
module pmo_output_port_monitor
   import pmo_pkg::*;
(
   // clock and reset
   input wire logic               ref_clk,
   input wire logic               rst_b,
   // bus pins
   input wire logic               scl_i,
   input wire logic               sda_i,
   input wire logic               sda_o,
   input wire logic               sda_oe,
   // measurement path
   input wire logic               sample_valid,
   input wire logic signed [15:0] volt_count,
   input wire logic signed [15:0] curr_count,
   input wire logic signed [15:0] power_count,
   // register contents
   input wire logic        [15:0] config_word,
   input wire logic        [15:0] measurement_result
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   // -------------------------------------------------------------------
   // properties
   // -------------------------------------------------------------------
   sequence s_load(logic [1:0] sel, logic signed [15:0] c);
      sample_valid && config_word[7:6] == sel && c <= FS_POS && c >= FS_NEG;
   endsequence
   property p_rst;
      @(posedge ref_clk) disable iff (1'b0) !rst_b |=>
         config_word == CFG_RESET && measurement_result == RESULT_RESET;
   endproperty
   property p_volt;
      s_load(SEL_VOLT, volt_count) |=>
         measurement_result[15:6] == $past(volt_count[9:0]);
   endproperty
   property p_curr;
      s_load(SEL_CURR, curr_count) |=>
         measurement_result[15:6] == $past(curr_count[9:0]);
   endproperty
   property p_power;
      s_load(SEL_POWER, power_count) |=>
         measurement_result[15:6] == $past(power_count[9:0]);
   endproperty
   property p_hold;
      !sample_valid |=> $stable(measurement_result);
   endproperty
   property p_pad;
      measurement_result[5:0] == 6'h00;
   endproperty
   property p_sign;
      measurement_result[15] |-> measurement_result[14];
   endproperty
   property p_undef;
      config_word[7:6] != SEL_UNDEF;
   endproperty
   property p_commit;
      $changed(config_word) |-> !scl_i;
   endproperty
   property p_drive;
      sda_oe |-> sda_o == BUS_ACK;
   endproperty
   a_rst: assert property (p_rst) else $error("bad reset");
   a_volt: assert property (p_volt) else $error("volt load");
   a_curr: assert property (p_curr) else $error("curr load");
   a_power: assert property (p_power) else $error("power load");
   a_hold: assert property (p_hold) else $error("result moved");
   a_pad: assert property (p_pad) else $error("pad bits");
   a_sign: assert property (p_sign) else $error("sign bit");
   a_undef: assert property (p_undef) else $error("select 11");
   a_commit: assert property (p_commit) else $error("commit");
   a_drive: assert property (p_drive) else $error("drive level");
endmodule // pmo_output_port_monitor

bind pmo_output_port pmo_output_port_monitor i_pmo_output_port_monitor (
   .ref_clk, .rst_b, .scl_i, .sda_i, .sda_o, .sda_oe, .sample_valid,
   .volt_count, .curr_count, .power_count, .config_word,
   .measurement_result
);

// file: sim/pmo_host.sv
// Purpose: two-wire bus master model
// Assumes: 400 ns bus clock, quarters on falling ref_clk
// Notes:   sda_pull high pulls the wire low
module pmo_host (
   // clock
   input  wire logic ref_clk,
   // bus lines
   input  wire logic sda,
   output logic      scl,
   output logic      sda_pull
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end
   task automatic q;
      repeat (2) @(negedge ref_clk);
   endtask
   // start or repeated start
   task automatic start;
      sda_pull = 1'b0;
      q();
      scl = 1'b1;
      q();
      sda_pull = 1'b1;
      q();
      scl = 1'b0;
      q();
   endtask
   task automatic stop;
      sda_pull = 1'b1;
      q();
      scl = 1'b1;
      q();
      sda_pull = 1'b0;
      q();
   endtask
   task automatic bit_slot(input logic b, output logic r);
      sda_pull = !b;
      q();
      scl = 1'b1;
      q();
      r = sda;
      q();
      scl = 1'b0;
      q();
   endtask
   // eight bits then the ack slot; send all ones to read
   task automatic xfer(input logic [7:0] d, input logic last,
                       output logic [7:0] rd, output logic ack);
      for (int i = 7; i >= 0; i--) bit_slot(d[i], rd[i]);
      bit_slot(last, ack);
   endtask
endmodule // pmo_host

// file: sim/pmo_output_port_tb.sv
// Purpose: self-checking bench of the output port
// Assumes: pmo_host as bus master
// Notes:   run ends in end_sim
module pmo_output_port_tb
   import pmo_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [6:0] ADDR = 7'h10;
   logic               ref_clk      = 1'b0;
   logic               rst_b        = 1'b0;
   logic               sample_valid = 1'b0;
   logic signed [15:0] volt_count   = 16'sh0;
   logic signed [15:0] curr_count   = 16'sh0;
   logic signed [15:0] power_count  = 16'sh0;
   logic               scl, sda_pull, sda_o, sda_oe, sda;
   logic        [15:0] config_word, measurement_result;
   logic        [15:0] last_res     = 16'h0;
   int                 bad_count    = 0;
   int                 n_checks     = 0;
   assign sda = !(sda_pull || sda_oe);
   always #25 ref_clk = !ref_clk;
   pmo_output_port i_pmo_output_port (
      .ref_clk, .rst_b, .scl_i(scl), .sda_i(sda), .sda_o, .sda_oe,
      .sample_valid, .volt_count, .curr_count, .power_count,
      .config_word, .measurement_result
   );
   pmo_host i_pmo_host (.ref_clk, .sda, .scl, .sda_pull);
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic wr_cfg(input logic [15:0] w);
      logic [7:0] rd;
      logic [3:0] a;
      i_pmo_host.start();
      i_pmo_host.xfer({ADDR, 1'b0}, 1'b1, rd, a[0]);
      i_pmo_host.xfer(CMD_CONFIG, 1'b1, rd, a[1]);
      i_pmo_host.xfer(w[7:0], 1'b1, rd, a[2]);
      i_pmo_host.xfer(w[15:8], 1'b1, rd, a[3]);
      i_pmo_host.stop();
      chk({12'h0, a}, 16'h0);
   endtask
   task automatic rd_reg(input logic [7:0] cmd, input logic [15:0] exp);
      logic [7:0] lo, hi;
      logic [4:0] a;
      i_pmo_host.start();
      i_pmo_host.xfer({ADDR, 1'b0}, 1'b1, lo, a[0]);
      i_pmo_host.xfer(cmd, 1'b1, lo, a[1]);
      i_pmo_host.start();
      i_pmo_host.xfer({ADDR, 1'b1}, 1'b1, lo, a[2]);
      i_pmo_host.xfer(8'hff, 1'b0, lo, a[3]);
      i_pmo_host.xfer(8'hff, 1'b1, hi, a[4]);
      i_pmo_host.stop();
      chk({11'h0, a}, 16'h10);
      chk({hi, lo}, exp);
   endtask
   // select a type, load counts, read through all three codes
   task automatic t_load(input logic [1:0] sel,
                         input logic signed [15:0] c, input logic [15:0] exp);
      wr_cfg({8'h00, sel, 6'h00});
      chk(config_word, {8'h00, sel, 6'h00});
      chk(measurement_result, last_res);
      volt_count = (sel == SEL_VOLT) ? c : 16'sh7;
      curr_count = (sel == SEL_CURR) ? c : -16'sh9;
      power_count = (sel == SEL_POWER) ? c : 16'sh3;
      sample_valid = 1'b1;
      @(negedge ref_clk);
      sample_valid = 1'b0;
      chk(measurement_result, exp);
      last_res = exp;
      rd_reg(CMD_RD_VOLT, exp);
      rd_reg(CMD_RD_CURR, exp);
      rd_reg(CMD_RD_POWER, exp);
   endtask
   task automatic t_refuse;
      logic [7:0] rd;
      logic [2:0] a;
      wr_cfg(16'h12c5);
      chk(config_word, 16'h1245);
      rd_reg(CMD_CONFIG, 16'h1245);
      i_pmo_host.start();
      i_pmo_host.xfer({ADDR, 1'b0}, 1'b1, rd, a[0]);
      // unassigned code; reserved codes are never sent
      i_pmo_host.xfer(8'h55, 1'b1, rd, a[1]);
      i_pmo_host.stop();
      i_pmo_host.start();
      i_pmo_host.xfer({ADDR ^ 7'h01, 1'b0}, 1'b1, rd, a[2]);
      i_pmo_host.stop();
      chk({13'h0, a}, 16'h6);
   endtask
   initial begin
      repeat (10) @(negedge ref_clk);
      rst_b = 1'b1;
      repeat (3) @(negedge ref_clk);
      chk(config_word, CFG_RESET);
      chk(measurement_result, RESULT_RESET);
      t_load(SEL_CURR, -16'sd256, 16'hc000);
      t_load(SEL_POWER, 16'sd0, 16'h0000);
      t_load(SEL_POWER, -16'sd1, 16'hffc0);
      t_load(SEL_CURR, 16'sd37, 16'h0940);
      t_load(SEL_VOLT, 16'sd256, 16'h4000);
      t_load(SEL_VOLT, 16'sd300, 16'h4000);
      t_refuse();
      end_sim();
   end
   initial begin
      #3000000;
      bad_count++;
      end_sim();
   end
endmodule // pmo_output_port_tb
